/* rtl/sli_pkg.sv */
// sli_pkg: constants and carrier types for the status indicator block
// assumes a 250 MHz core clock; shared by the indicator top and its pin cell
package sli_pkg;

  // display modes, one-hot
  typedef enum logic [2:0] {
    SLI_MODE_ONE   = 3'h1,
    SLI_MODE_TWO   = 3'h2,
    SLI_MODE_THREE = 3'h4
  } sli_mode_t;

  // core clock rate and blink timing
  localparam int unsigned SLI_CLK_MHZ       = 250;
  localparam int unsigned SLI_BLINK_HALF_MS = 50;
  localparam int unsigned SLI_BLINK_CYCLES  = SLI_BLINK_HALF_MS * 1000 * SLI_CLK_MHZ;
  localparam int unsigned SLI_CNT_W         = 24;

  // pin index positions inside the three-pin vectors
  localparam int unsigned SLI_PIN_ACT   = 0;
  localparam int unsigned SLI_PIN_SPEED = 1;
  localparam int unsigned SLI_PIN_LINK  = 2;
  localparam int unsigned SLI_NPINS     = 3;

  // reset values
  localparam logic [2:0] SLI_DIR_RST = 3'h0;
  localparam logic       SLI_OFF     = 1'b0;

  // link state coming from the transceiver core
  typedef struct packed {
    logic link_good;
    logic speed_100;
    logic full_duplex;
    logic collision;
    logic tx_active;
    logic rx_active;
  } sli_status_t;

  // direct control from the management side, one bit per shared pin
  typedef struct packed {
    logic [2:0] indicator_off;  // indicator function disabled, pin is an event pin
    logic [2:0] event_dir_out;  // event pin drives when 1, listens when 0
    logic [2:0] event_out;      // value driven on an event output
  } sli_ctrl_t;

endpackage

/* rtl/sli_pin_cell.sv */
// sli_pin_cell: one shared indicator / event pin
// assumes all inputs synchronous to core_clk_i; output enable is low while driving
`timescale 1ns/1ps
`default_nettype none
module sli_pin_cell
  import sli_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic clk_en_i,
  input  wire logic indicator_i,
  input  wire logic indicator_off_i,
  input  wire logic event_dir_out_i,
  input  wire logic event_out_i,
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe_n_o,
  output logic      event_in_o
);

  // pin drive: indicator value, or event value when repurposed
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_o      <= SLI_OFF;
      pin_oe_n_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pin_o      <= indicator_off_i ? event_out_i : indicator_i;   // [RULE8]
      pin_oe_n_o <= indicator_off_i & ~event_dir_out_i;            // [RULE9]
    end
  end

  // event detect: pin level seen only while the pin listens
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      event_in_o <= 1'b0;
    else if (clk_en_i)
      event_in_o <= indicator_off_i & ~event_dir_out_i & pin_i;    // [RULE9]
  end

endmodule
`default_nettype wire

/* rtl/sli_indicator.sv */
// sli_indicator: three status indicator pins shared with event pins five to seven
// pin order: bit 0 activity (event five), bit 1 speed (event six), bit 2 link (event seven)
// every pin output is registered in its cell, one edge behind status_i
// assumes status inputs synchronous to core_clk_i; strap is stable around reset release
// assumes clk_en_i low freezes every register; mode_three_sel_i comes from a register
// limitation: the blink phase runs free, so a burst may wait up to half a period to blink
//
// Contract
// [RULE1] three indicator outputs; strap picks mode one or two, register picks three
// [RULE2] mode one: link indicator on while link good, off otherwise
// [RULE3] modes two and three: link indicator on when link good, blinks on activity
// [RULE4] speed indicator on at 100 Mb/s, off at 10 Mb/s, any mode
// [RULE5] mode one: activity indicator on during transmit or receive activity
// [RULE6] mode two: activity indicator shows collision detection
// [RULE7] mode three: activity indicator shows full duplex; the code lights it only while link good is also set
// [RULE8] software disables indicator function before using pins as event pins
// [RULE9] repurposed pin acts as event output or event input
// [RULE10] blink period fixed, derived from the core clock
`timescale 1ns/1ps
`default_nettype none
module sli_indicator
  import sli_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = SLI_BLINK_CYCLES
)
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        clk_en_i,
  input  wire logic        mode_strap_i,     // 0 selects mode one, 1 mode two
  input  wire logic        mode_three_sel_i, // register setting selecting mode three
  input  wire sli_status_t status_i,
  input  wire sli_ctrl_t   ctrl_i,
  input  wire logic [2:0]  pin_i,
  output logic [2:0]       pin_o,
  output logic [2:0]       pin_oe_n_o,
  output logic [2:0]       event_in_o,
  output sli_mode_t        mode_o
);

  logic                 strap_taken_q;
  logic                 strap_q;
  logic                 strap_mode;
  sli_mode_t            mode_d;
  logic [SLI_CNT_W-1:0] blink_cnt_q;
  logic                 blink_wrap;
  logic                 blink_phase_q;
  logic                 blink_off;
  logic                 act_stretch_q;
  logic [SLI_CNT_W:0]   stretch_cnt_q;   // one bit wider: twice the half period needs it
  logic                 stretch_done;
  logic                 link_ind;
  logic                 speed_ind;
  logic                 act_ind;
  logic [2:0]           ind_d;
  logic                 activity;

  // traffic in either direction counts as activity
  assign activity = status_i.tx_active | status_i.rx_active;

  // strap caught at the first enabled edge after reset release, never under reset
  // reading the pin under reset could catch it while it is still settling
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      strap_taken_q <= 1'b0;
      strap_q       <= 1'b0;
    end
    else if (clk_en_i && !strap_taken_q)
    begin
      strap_taken_q <= 1'b1;
      strap_q       <= mode_strap_i;                               // [RULE1]
    end
  end

  // strap as seen this edge: live level until the capture edge, held copy after
  assign strap_mode = strap_taken_q ? strap_q : mode_strap_i;

  // next mode: register choice overrides the strap
  // mode three has no strap value; only the register reaches it
  always_comb
  begin
    mode_d = SLI_MODE_ONE;
    if (mode_three_sel_i)
      mode_d = SLI_MODE_THREE;                                     // [RULE1]
    else if (strap_mode)
      mode_d = SLI_MODE_TWO;                                       // [RULE1]
    else
      mode_d = SLI_MODE_ONE;
  end

  // mode register; pins follow a mode change one edge after mode_o moves
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mode_o <= SLI_MODE_ONE;
    else if (clk_en_i)
      mode_o <= mode_d;
  end

  // end of one half period of the blink timebase
  assign blink_wrap = blink_cnt_q >= SLI_CNT_W'(BLINK_CYCLES - 1);

  // free-running blink timebase; half period is BLINK_CYCLES
  // phase starts low after reset, so the first dark phase comes one half period in
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      blink_cnt_q   <= '0;
      blink_phase_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (blink_wrap)
      begin
        blink_cnt_q   <= '0;
        blink_phase_q <= ~blink_phase_q;                           // [RULE10]
      end
      else
        blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  // counter at zero: the stretched on-time has run out
  assign stretch_done = (stretch_cnt_q == '0);

  // stretch short bursts so a single frame still gives one visible blink;
  // twice the half period always overlaps dark phases for one half period in total
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      act_stretch_q <= 1'b0;
      stretch_cnt_q <= '0;
    end
    else if (clk_en_i)
    begin
      if (activity)
      begin
        act_stretch_q <= 1'b1;                                     // [RULE10]
        stretch_cnt_q <= (SLI_CNT_W+1)'(2 * BLINK_CYCLES - 1);
      end
      else if (!stretch_done)
        stretch_cnt_q <= stretch_cnt_q - 1'b1;
      else
        act_stretch_q <= 1'b0;
    end
  end

  // link pin blinks dark only while activity is stretched and the phase is high
  assign blink_off = act_stretch_q & blink_phase_q;

  // link pin per mode; steady in mode one
  // a dropped link always wins over the blink
  always_comb
  begin
    link_ind = status_i.link_good;
    case (mode_o)
      SLI_MODE_ONE:
        link_ind = status_i.link_good;                             // [RULE2]
      SLI_MODE_TWO:
        link_ind = status_i.link_good & ~blink_off;                // [RULE3]
      SLI_MODE_THREE:
        link_ind = status_i.link_good & ~blink_off;                // [RULE3]
      default:
        link_ind = status_i.link_good;
    endcase
  end

  // activity pin per mode
  // duplex only means something while the link is up, so it is gated by it
  always_comb
  begin
    act_ind = 1'b0;
    case (mode_o)
      SLI_MODE_ONE:
        act_ind = activity;                                        // [RULE5]
      SLI_MODE_TWO:
        act_ind = status_i.collision;                              // [RULE6]
      SLI_MODE_THREE:
        act_ind = status_i.full_duplex & status_i.link_good;       // [RULE7]
      default:
        act_ind = 1'b0;
    endcase
  end

  // speed pin ignores the mode
  assign speed_ind = status_i.speed_100;                           // [RULE4]

  // gather the three pins in package order
  always_comb
  begin
    ind_d                = 3'h0;
    ind_d[SLI_PIN_LINK]  = link_ind;
    ind_d[SLI_PIN_SPEED] = speed_ind;
    ind_d[SLI_PIN_ACT]   = act_ind;
  end

  // one shared pin cell per indicator; the cell registers every output
  // so every top-level pin output comes straight from a flip-flop
  genvar g;
  generate
    for (g = 0; g < SLI_NPINS; g++)
    begin : g_pin
      sli_pin_cell u_cell (
        .core_clk_i      (core_clk_i),
        .nrst_i          (nrst_i),
        .clk_en_i        (clk_en_i),
        .indicator_i     (ind_d[g]),
        .indicator_off_i (ctrl_i.indicator_off[g]),                // [RULE8]
        .event_dir_out_i (ctrl_i.event_dir_out[g]),
        .event_out_i     (ctrl_i.event_out[g]),
        .pin_i           (pin_i[g]),
        .pin_o           (pin_o[g]),
        .pin_oe_n_o      (pin_oe_n_o[g]),
        .event_in_o      (event_in_o[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

/* bench/sli_indicator_assertions.sv */
// sli_indicator_assertions: port checks for the indicator block
// assumes one core clock domain; bound to every sli_indicator
`timescale 1ns/1ps
`default_nettype none
module sli_indicator_assertions
  import sli_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        clk_en_i,
  input wire logic        mode_three_sel_i,
  input wire sli_status_t status_i,
  input wire sli_ctrl_t   ctrl_i,
  input wire logic [2:0]  pin_i,
  input wire logic [2:0]  pin_o,
  input wire logic [2:0]  pin_oe_n_o,
  input wire logic [2:0]  event_in_o,
  input wire sli_mode_t   mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // pins follow the status one edge later; mode_o of the same edge selects
  wire logic on = clk_en_i && ctrl_i.indicator_off == 3'h0;
  wire logic off = clk_en_i && &ctrl_i.indicator_off;
  a_speed_pin: assert property (on |=> pin_o[1] == $past(status_i.speed_100))
    else $error("speed pin wrong");
  a_link_plain: assert property (on && mode_o == SLI_MODE_ONE |=>
    pin_o[2] == $past(status_i.link_good)) else $error("link pin wrong");
  a_link_down: assert property (on && mode_o != SLI_MODE_ONE && !status_i.link_good
    |=> !pin_o[2]) else $error("link pin lit without link");
  a_act_plain: assert property (on && mode_o == SLI_MODE_ONE |=>
    pin_o[0] == $past(status_i.tx_active | status_i.rx_active)) else $error("act pin");
  a_act_coll: assert property (on && mode_o == SLI_MODE_TWO |=>
    pin_o[0] == $past(status_i.collision)) else $error("collision pin");
  a_act_duplex: assert property (on && mode_o == SLI_MODE_THREE |=>
    pin_o[0] == $past(status_i.full_duplex & status_i.link_good)) else $error("duplex pin");
  a_mode_sel: assert property (clk_en_i && mode_three_sel_i |=> mode_o == SLI_MODE_THREE)
    else $error("mode three not taken");
  a_event_out: assert property (off |=> pin_o == $past(ctrl_i.event_out) &&
    pin_oe_n_o == ~$past(ctrl_i.event_dir_out)) else $error("event drive");
  a_event_in: assert property (off |=>
    event_in_o == ($past(pin_i) & ~$past(ctrl_i.event_dir_out))) else $error("event in");
endmodule
bind sli_indicator sli_indicator_assertions u_chk (.core_clk_i, .nrst_i, .clk_en_i,
  .mode_three_sel_i, .status_i, .ctrl_i, .pin_i, .pin_o, .pin_oe_n_o, .event_in_o, .mode_o);
`default_nettype wire

/* bench/sli_led_board.sv */
// sli_led_board: board side of the three shared pins, leds with pull-ups
// assumes the device drives a pin only while its enable is low
`timescale 1ns/1ps
`default_nettype none
module sli_led_board (
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe_n_o,
  input  wire logic [2:0] ext_en_i,
  input  wire logic [2:0] ext_val_i,
  output logic [2:0]      pin_i,
  output logic [2:0]      led_o
);
  // a released pin goes to its pull-up unless an outside event source drives it
  assign pin_i = ~pin_oe_n_o & pin_o | pin_oe_n_o & (ext_en_i & ext_val_i | ~ext_en_i);
  assign led_o = pin_o & ~pin_oe_n_o;
endmodule
`default_nettype wire

/* bench/sli_indicator_tb_top.sv */
// sli_indicator_tb_top: directed scenarios for the indicator block
// assumes registered pins one cycle behind inputs, blink count shrunk to 4
`timescale 1ns/1ps
`default_nettype none
module sli_indicator_tb_top;
  import sli_pkg::*;
  logic        core_clk_i = 0, nrst_i = 0, mode_strap_i = 0, mode_three_sel_i = 0;
  logic        clk_en = 1;
  sli_status_t status_i = '0;
  sli_ctrl_t   ctrl_i = '0;
  logic [2:0]  ext_en = '0, ext_val = '0, pin_i, pin_o, pin_oe_n_o, event_in_o, led;
  sli_mode_t   mode_o;
  int          n_errors = 0, n_checks = 0, lo;
  always #2 core_clk_i = ~core_clk_i;
  sli_indicator #(.BLINK_CYCLES(4)) uut (.core_clk_i, .nrst_i, .clk_en_i(clk_en), .mode_strap_i,
    .mode_three_sel_i, .status_i, .ctrl_i, .pin_i, .pin_o, .pin_oe_n_o, .event_in_o, .mode_o);
  sli_led_board board (.pin_o, .pin_oe_n_o, .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_i,
    .led_o(led));
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs move on the falling edge, results are read one full cycle later
  task automatic step(input logic [5:0] s);
    @(negedge core_clk_i) status_i = s;
    @(negedge core_clk_i);
  endtask
  task automatic rst(input logic strap);
    nrst_i = 0;
    mode_strap_i = strap;
    repeat (16) @(negedge core_clk_i);
    nrst_i = 1;
    repeat (2) @(negedge core_clk_i);
  endtask
  task automatic t_modes;
    logic [5:0] s;
    rst(0);
    chk(mode_o, 3'h1);
    for (int i = 0; i < 6; i++)
    begin
      s = 6'h01 << i;
      step(s);
      chk(pin_o, {s[5], s[4], s[1] | s[0]});
    end
    rst(1);
    chk(mode_o, 3'h2);
    for (int i = 2; i < 6; i++)
    begin
      s = 6'h01 << i;
      step(s);
      chk(pin_o, {s[5], s[4], s[2]});
    end
    mode_three_sel_i = 1;
    for (int i = 2; i < 6; i++)
    begin
      s = 6'h20 | (6'h01 << i);
      step(s);
      chk(pin_o, {1'b1, s[4], s[3]});
    end
    chk(mode_o, 3'h4);
    $display("mode tests done");
  endtask
  task automatic t_blink;
    lo = 0;
    step(6'h22);
    repeat (16) @(negedge core_clk_i) lo += !pin_o[2];
    chk(3'(lo > 0), 3'h1);
    step(6'h20);
    repeat (10) @(negedge core_clk_i);
    lo = 0;
    repeat (8) @(negedge core_clk_i) lo += !pin_o[2];
    chk(3'(lo), 3'h0);
    $display("blink test done");
  endtask
  task automatic t_event;
    ctrl_i = '{indicator_off: 3'h7, event_dir_out: 3'h5, event_out: 3'h1};
    ext_en = 3'h2;
    step(6'h3f);
    chk(pin_oe_n_o, 3'h2);
    chk(pin_o, 3'h1);
    chk(event_in_o, 3'h0);
    ext_val = 3'h2;
    step(6'h3f);
    chk(event_in_o, 3'h2);
    $display("event test done");
  endtask
  // a low clock enable holds pins and mode whatever the inputs do
  task automatic t_freeze;
    step(6'h20);
    clk_en = 0;
    status_i = 6'h30;
    mode_three_sel_i = 0;
    repeat (4) @(negedge core_clk_i);
    chk(pin_o, 3'h4);
    chk(mode_o, 3'h4);
    clk_en = 1;
    @(negedge core_clk_i);
    chk(pin_o, 3'h6);
    chk(mode_o, 3'h2);
    $display("freeze test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    t_modes();
    t_blink();
    t_freeze();
    t_event();
    give_verdict();
  end
  // the whole sequence takes just over a hundred cycles
  initial
  begin
    #20000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
